//--- rtl/ccrmd_params.svh
// constants of the processor card reset and memory decode glue
// assumes a 200 MHz system clock; times are converted to cycle counts here
// Contract
// - system reset is asserted when power-on or pushbutton reset is active
// - power-on one-shot holds system reset low at most 50 ms
// - pushbutton input is synchronised to the state timing before use
// - pushbutton reset holds system reset low at most 10 us
// - default map selects onboard eprom for addresses 0000-1FFF
// - default map selects onboard ram (4096 bytes) for 2000-2FFF
// - jumper disables onboard memory or moves 12K region to C000-EFFF
// - expansion lines held grounded through removable links
// - state timing derived from crystal, 400 ns states
// - bus interface can be disabled for another bus master
`ifndef CCRMD_PARAMS_SVH
`define CCRMD_PARAMS_SVH
`define CCRMD_CLK_MHZ 200
`define CCRMD_POR_MS 50
`define CCRMD_POR_CYC (`CCRMD_POR_MS * 1000 * `CCRMD_CLK_MHZ)
`define CCRMD_PB_US 10
`define CCRMD_PB_CYC (`CCRMD_PB_US * `CCRMD_CLK_MHZ)
`define CCRMD_STATE_NS 400
`define CCRMD_STATE_CYC (`CCRMD_STATE_NS * `CCRMD_CLK_MHZ / 1000)
`define CCRMD_ROM_PAGE 4'h0
`define CCRMD_ROM_PAGE_HI 4'h1
`define CCRMD_RAM_PAGE 4'h2
`define CCRMD_REMAP_PAGE 4'hC
`endif

//--- rtl/ccrmd_pkg.sv
// types of the processor card reset and memory decode glue
// shared by the design and the bench
package ccrmd_pkg;
  typedef enum logic [1:0] {
    CCRMD_MAP_DEFAULT = 2'b00,
    CCRMD_MAP_REMAP = 2'b01,
    CCRMD_MAP_OFF = 2'b10
  } ccrmd_map_e;
  typedef enum logic [1:0] {
    CCRMD_RS_POR = 2'b00,
    CCRMD_RS_RUN = 2'b01,
    CCRMD_RS_PB = 2'b10,
    CCRMD_RS_WAIT = 2'b11
  } ccrmd_rst_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic rd_n;
    logic wr_n;
    logic memrq_n;
    logic iorq_n;
  } ccrmd_bus_s;
  typedef struct packed {
    logic rom_sel_n;
    logic ram_sel_n;
    logic [1:0] rom_bank;
    logic [2:0] ram_bank;
    logic ext_block;
  } ccrmd_sel_s;
endpackage

//--- rtl/ccrmd_glue.sv
// reset generator, memory decoder and bus driver control of the cpu card
// assumes cpu bus inputs and jumper levels synchronous to clk_sys
`timescale 1ns/100ps
`include "ccrmd_params.svh"
module ccrmd_glue
  import ccrmd_pkg::*;
#(
  parameter int POR_CYC = `CCRMD_POR_CYC,
  parameter int PB_CYC = `CCRMD_PB_CYC,
  parameter int STATE_CYC = `CCRMD_STATE_CYC
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pb_reset_n,
  input wire ccrmd_map_e map_jumper,
  input wire logic exp_link_fitted,
  input wire logic bus_disable,
  input wire ccrmd_bus_s cpu_bus,
  input wire logic [7:0] bus_data_in,
  output logic sys_reset_n,
  output logic state_tick,
  output ccrmd_sel_s mem_sel,
  output ccrmd_bus_s bus_out,
  output logic bus_oe,
  output logic [7:0] cpu_data_in,
  output logic memex_o,
  output logic memex_oe,
  output logic ioexp_o,
  output logic ioexp_oe
);
  localparam int CW = $clog2(POR_CYC + 1);
  localparam int SW = $clog2(STATE_CYC + 1);

  // offset wraps modulo 16, so a window reaching the top of memory still matches
  function automatic logic page_hit(input logic [3:0] page, input logic [3:0] base,
                                    input logic [3:0] span);
    logic [3:0] ofs;
    begin
      ofs = page - base;
      page_hit = ofs < span;
    end
  endfunction

  logic rst_s1_r;
  logic rst_s2_r;
  logic pb_s1_r;
  logic pb_s2_r;
  logic pb_st_r;
  logic [SW-1:0] st_cnt_r;
  logic tick_r;
  ccrmd_rst_e rs_r;
  ccrmd_rst_e rs_nxt;
  logic [CW-1:0] cnt_r;
  logic sysrst_r;
  logic [3:0] base;
  logic [3:0] pg;
  logic on_rom;
  logic on_ram;
  ccrmd_sel_s sel_nxt;
  ccrmd_sel_s sel_r;
  ccrmd_bus_s bus_r;
  logic [7:0] din_r;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // state time generator, one tick per 400 ns state
  always_ff @(posedge clk_sys or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      st_cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (st_cnt_r == SW'(STATE_CYC - 1))
    begin
      st_cnt_r <= '0;
      tick_r <= 1'b1;
    end
    else
    begin
      st_cnt_r <= st_cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end
  assign state_tick = tick_r;

  // two-stage sync, then sampled only on state ticks
  // a press shorter than one state can be missed; a hand on a button is far slower
  always_ff @(posedge clk_sys or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      pb_s1_r <= 1'b1;
      pb_s2_r <= 1'b1;
      pb_st_r <= 1'b1;
    end
    else
    begin
      pb_s1_r <= pb_reset_n;
      pb_s2_r <= pb_s1_r;
      if (tick_r)
        pb_st_r <= pb_s2_r;
    end
  end

  // power-on hold and pushbutton pulse share one counter; release wait ends on the button alone
  always_comb
  begin
    rs_nxt = rs_r;
    case (rs_r)
      CCRMD_RS_POR:
        if (cnt_r == CW'(POR_CYC - 1))
          rs_nxt = CCRMD_RS_RUN;
      CCRMD_RS_RUN:
        if (!pb_st_r)
          rs_nxt = CCRMD_RS_PB;
      CCRMD_RS_PB:
        if (cnt_r == CW'(PB_CYC - 1))
          rs_nxt = CCRMD_RS_WAIT;
      CCRMD_RS_WAIT:
        // a held button retriggers nothing; wait for release
        if (pb_st_r)
          rs_nxt = CCRMD_RS_RUN;
      default:
        rs_nxt = CCRMD_RS_POR;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      rs_r <= CCRMD_RS_POR;
      cnt_r <= '0;
      sysrst_r <= 1'b0;
    end
    else
    begin
      rs_r <= rs_nxt;
      // restarts on every state change, so each interval counts from zero
      cnt_r <= (rs_nxt != rs_r) ? '0 : cnt_r + 1'b1;
      sysrst_r <= (rs_nxt == CCRMD_RS_RUN) || (rs_nxt == CCRMD_RS_WAIT);
    end
  end
  assign sys_reset_n = sysrst_r;

  // decode: rom pages 0-1, ram page 2 relative to base
  always_comb
  begin
    base = (map_jumper == CCRMD_MAP_REMAP) ? `CCRMD_REMAP_PAGE : `CCRMD_ROM_PAGE;
    pg = cpu_bus.addr[15:12] - base;
    on_rom = (map_jumper != CCRMD_MAP_OFF) && !cpu_bus.memrq_n
      && page_hit(cpu_bus.addr[15:12], base, 4'h2);
    on_ram = (map_jumper != CCRMD_MAP_OFF) && !cpu_bus.memrq_n
      && page_hit(cpu_bus.addr[15:12], 4'(base + `CCRMD_RAM_PAGE), 4'h1);
    sel_nxt.rom_sel_n = !on_rom;
    sel_nxt.ram_sel_n = !on_ram;
    sel_nxt.rom_bank = {pg == `CCRMD_ROM_PAGE_HI, cpu_bus.addr[11]};
    sel_nxt.ram_bank = cpu_bus.addr[11:9];
    // whole 16K window stays reserved while onboard memory is on
    sel_nxt.ext_block = (map_jumper != CCRMD_MAP_OFF)
      && page_hit(cpu_bus.addr[15:12], base, 4'h4);
  end

  // selects idle high only while rst_n reset is in progress; during the power-on and pushbutton holds they follow the decode
  always_ff @(posedge clk_sys or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      sel_r <= '{rom_sel_n: 1'b1, ram_sel_n: 1'b1, default: '0};
    end
    else
    begin
      sel_r <= sel_nxt;
    end
  end

  // registered copy toward the backplane drivers, strobes idle high
  always_ff @(posedge clk_sys or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      bus_r <= '{rd_n: 1'b1, wr_n: 1'b1, memrq_n: 1'b1, iorq_n: 1'b1, default: '0};
    end
    else
    begin
      bus_r <= cpu_bus;
    end
  end

  // backplane data taken one cycle late, like the outgoing copy
  always_ff @(posedge clk_sys or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      din_r <= '0;
    end
    else
    begin
      din_r <= bus_data_in;
    end
  end

  assign mem_sel = sel_r;
  assign bus_out = bus_r;
  assign cpu_data_in = din_r;
  // drivers released while another master owns the bus or card in reset
  assign bus_oe = !bus_disable && sysrst_r;

  // links only ground the lines; a removed link leaves them to the backplane
  assign memex_o = 1'b0;
  assign ioexp_o = 1'b0;
  assign memex_oe = exp_link_fitted;
  assign ioexp_oe = exp_link_fitted;
endmodule

//--- tb/ccrmd_assertions.sv
// reset, decode and drive checks of the card glue
// bound into ccrmd_glue, sees its ports only
`timescale 1ns/100ps
module ccrmd_assertions
  import ccrmd_pkg::*;
#(
  parameter int POR_CYC = 200,
  parameter int PB_CYC = 20,
  parameter int STATE_CYC = 4
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pb_reset_n,
  input wire ccrmd_map_e map_jumper,
  input wire ccrmd_bus_s cpu_bus,
  input wire logic bus_disable,
  input wire logic sys_reset_n,
  input wire logic state_tick,
  input wire ccrmd_sel_s mem_sel,
  input wire logic bus_oe
);
  localparam int PMAX = POR_CYC + 6;
  localparam int SMAX = STATE_CYC + 8;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_por; $rose(rst_n) |-> ##[1:PMAX] sys_reset_n; endproperty
  a_por: assert property (p_por) else $error("por");
  property p_pb; $fell(sys_reset_n) |-> ##[1:PB_CYC] sys_reset_n; endproperty
  a_pb: assert property (p_pb) else $error("pb");
  property p_sy; $fell(pb_reset_n) && sys_reset_n |=> sys_reset_n ##[1:SMAX] !sys_reset_n;
  endproperty
  a_sy: assert property (p_sy) else $error("sync");
  // period of four assumes STATE_CYC of 4
  property p_tk; $rose(state_tick) |=> !state_tick[*3] ##1 state_tick; endproperty
  a_tk: assert property (p_tk) else $error("tick");
  property p_rom; sys_reset_n && map_jumper == CCRMD_MAP_DEFAULT && cpu_bus.addr[15:13] == 3'h0
    && !cpu_bus.memrq_n |=> !mem_sel.rom_sel_n; endproperty
  a_rom: assert property (p_rom) else $error("rom");
  property p_ram; map_jumper == CCRMD_MAP_DEFAULT && cpu_bus.addr[15:12] == 4'h2
    && !cpu_bus.memrq_n |=> !mem_sel.ram_sel_n && mem_sel.rom_sel_n; endproperty
  a_ram: assert property (p_ram) else $error("ram");
  property p_map; map_jumper == CCRMD_MAP_REMAP && cpu_bus.addr[15:12] == 4'hE
    && !cpu_bus.memrq_n |=> !mem_sel.ram_sel_n && mem_sel.ext_block; endproperty
  a_map: assert property (p_map) else $error("remap");
  property p_oe; bus_disable |-> !bus_oe; endproperty
  a_oe: assert property (p_oe) else $error("oe");
endmodule
bind ccrmd_glue ccrmd_assertions #(.POR_CYC(POR_CYC), .PB_CYC(PB_CYC),
  .STATE_CYC(STATE_CYC)) chk (.*);

//--- tb/ccrmd_backplane.sv
// backplane memory card model answering reads
// assumes the registered bus copy of the glue
`timescale 1ns/100ps
module ccrmd_backplane
  import ccrmd_pkg::*;
(
  input wire logic clk_sys,
  input wire ccrmd_bus_s bus_out,
  input wire logic bus_oe,
  input wire logic ext_block,
  output logic [7:0] bus_data_in = 8'h5A
);
  // idle lines float: toggle so stale data never looks valid
  always @(posedge clk_sys)
    bus_data_in <= (bus_oe && !ext_block && !bus_out.rd_n) ? bus_out.addr[7:0] : ~bus_data_in;
endmodule

//--- tb/ccrmd_glue_bench.sv
// self-checking bench of the card glue
// inputs change at falling edge; decode notes queued and popped after rising edge
`timescale 1ns/100ps
module ccrmd_glue_bench
  import ccrmd_pkg::*;
;
  logic clk_sys = 0, rst_n = 0, pb_reset_n = 1, exp_link_fitted = 1, bus_disable = 0;
  ccrmd_map_e map_jumper = CCRMD_MAP_DEFAULT;
  ccrmd_bus_s cpu_bus = {16'h0000, 8'h00, 4'h5};
  logic sys_reset_n, state_tick, bus_oe, memex_o, memex_oe, ioexp_o, ioexp_oe;
  logic [7:0] bus_data_in, cpu_data_in;
  ccrmd_sel_s mem_sel;
  ccrmd_bus_s bus_out;
  int n_mismatch, total_checks, cyc, n;
  logic [15:0] rs = 16'h0C68;
  logic [2:0] q[$];
  logic [8:0] dq[$];
  logic [8:0] dh;
  logic [2:0] e;
  always #2.5 clk_sys = ~clk_sys;
  ccrmd_glue #(.POR_CYC(200), .PB_CYC(20), .STATE_CYC(4)) uut (.*);
  ccrmd_backplane bp (.clk_sys, .bus_out, .bus_oe, .ext_block(mem_sel.ext_block), .bus_data_in);
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [2:0] dec(ccrmd_map_e m, logic [15:0] a, logic mq);
    logic [3:0] d;
    d = a[15:12] - ((m == CCRMD_MAP_REMAP) ? 4'hC : 4'h0);
    return (m == CCRMD_MAP_OFF) ? 3'h6 : {d > 1 || mq, d != 2 || mq, d < 4};
  endfunction
  always @(posedge clk_sys)
  begin
    #1;
    cyc++;
    if (q.size() > 0)
      chk("sel", {mem_sel.rom_sel_n, mem_sel.ram_sel_n, mem_sel.ext_block}, q.pop_front());
    if (cyc == 2000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1;
    repeat (190) @(negedge clk_sys);
    chk("por", sys_reset_n, 0);
    for (n = 0; n < 30 && sys_reset_n !== 1; n++)
      @(negedge clk_sys);
    chk("por", sys_reset_n, 1);
    $display("power-on done");
    for (int m = 0; m < 3; m++)
      for (int p = 0; p < 16; p++)
      begin
        rs ^= rs << 7;
        rs ^= rs >> 9;
        rs ^= rs << 8;
        map_jumper = ccrmd_map_e'(m);
        cpu_bus.addr = {p[3:0], rs[11:0]};
        cpu_bus.memrq_n = rs[12];
        e = dec(map_jumper, cpu_bus.addr, cpu_bus.memrq_n);
        q.push_back(e);
        dq.push_back({!e[0], cpu_bus.addr[7:0]});
        @(negedge clk_sys);
        chk("bus", bus_out, cpu_bus);
        if (dq.size() == 3)
        begin
          dh = dq.pop_front();
          if (dh[8])
            chk("din", cpu_data_in, dh[7:0]);
        end
      end
    $display("decode done");
    pb_reset_n = 0;
    repeat (10) @(negedge clk_sys);
    pb_reset_n = 1;
    chk("pb", sys_reset_n, 0);
    for (n = 0; n < 40 && sys_reset_n === 0; n++)
      @(negedge clk_sys);
    chk("pbw", n <= 20, 1);
    $display("pushbutton done");
    bus_disable = 1;
    exp_link_fitted = 0;
    @(negedge clk_sys);
    chk("oe", bus_oe, 0);
    chk("lnk", {memex_oe, ioexp_oe, memex_o, ioexp_o}, 0);
    bus_disable = 0;
    exp_link_fitted = 1;
    @(negedge clk_sys);
    chk("oe", bus_oe, 1);
    chk("lnk", {memex_oe, ioexp_oe, memex_o, ioexp_o}, 4'hC);
    $display("drive done");
    complete_run();
  end
endmodule
